//--- verif/sector_protection_command_unit_bench.sv
// Self-checking bench for the sector protection command unit.
// Assumes sspcu_top, sspcu_host and the bound checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none

module sector_protection_command_unit_bench;
    import sspcu_pkg::*;
    localparam int PROG  = 24;
    localparam int ERASE = 500;

    logic        clk = 1'b0;
    logic        sys_rst, pwd_mode_bit, prog_fault;
    logic        sck, cs_n, si, so, so_oe, busy, wen, perr, lock;
    int          failures = 0;
    int          check_count = 0;
    int          seed;
    logic [7:0]  sec;
    logic [31:0] addr;
    logic [63:0] pw;

    sspcu_top #(.NUM_SECTORS(256), .PROG_CYCLES(PROG), .ERASE_CYCLES(ERASE)) u_sspcu_top
        (.clk(clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si),
         .pwd_mode_bit(pwd_mode_bit), .prog_fault(prog_fault), .so(so), .so_oe(so_oe),
         .op_in_progress_flag(busy), .write_enable_latch(wen), .program_error(perr),
         .prot_lock_bit(lock));
    sspcu_host u_sspcu_host
        (.clk(clk), .so(so), .so_oe(so_oe), .sck(sck), .cs_n(cs_n), .si(si));

    always #25 clk = ~clk;

    // ****
    // Helpers
    // ****
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic frame(input logic [7:0] op, input logic [63:0] arg, input int n);
        u_sspcu_host.xfer({op, arg}, n);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic wait_idle;
        for (int k = 0; k < 12; k++)
        begin
            frame(SSPCU_OP_RDSR, 64'h0, 16);
            if (u_sspcu_host.rx[0] === 1'b0)
                break;
        end
    endtask

    // Low byte first on the wire, each byte msb first
    function automatic logic [63:0] wire_order(input logic [63:0] p);
        logic [63:0] w;
        for (int i = 0; i < 8; i++)
            w[63 - 8 * i -: 8] = p[8 * i +: 8];
        return w;
    endfunction

    task automatic summarize;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****
    // Scenarios
    // ****
    initial
    begin
        seed = 32'h50a5_4e63;
        sys_rst = 1'b1;
        pwd_mode_bit = 1'b1;
        prog_fault = 1'b0;
        idle(8);
        @(posedge clk) sys_rst <= 1'b0;
        idle(2);
        check(lock, 1'b1);
        u_sspcu_host.half = 2 + ($random(seed) & 3);
        sec  = 8'($random(seed));
        addr = {6'h00, sec, 18'h0_0000};
        pw   = {$random(seed), $random(seed)};
        frame(SSPCU_OP_NV_READ, {addr, 32'h0}, 56);
        check(u_sspcu_host.rx[15:0], 16'hFFFF);
        frame(SSPCU_OP_NV_PROG, {addr, 32'h0}, 40);
        check({busy, wen}, 2'b00);
        frame(SSPCU_OP_WEN, 64'h0, 8);
        check(wen, 1'b1);
        frame(SSPCU_OP_NV_PROG, {addr, 32'h0}, 41);
        check(busy, 1'b0);
        frame(SSPCU_OP_NV_PROG, {addr, 32'h0}, 40);
        check(busy, 1'b1);
        wait_idle();
        check(wen, 1'b0);
        frame(SSPCU_OP_NV_READ, {addr, 32'h0}, 56);
        check(u_sspcu_host.rx[15:0], 16'h0000);
        frame(SSPCU_OP_NV_READ, {6'h00, sec + 8'h01, 18'h0_0000, 32'h0}, 48);
        check(u_sspcu_host.rx[7:0], 8'hFF);
        frame(SSPCU_OP_WEN, 64'h0, 8);
        frame(SSPCU_OP_NV_ERASE, 64'h0, 8);
        frame(SSPCU_OP_SUSPEND, 64'h0, 8);
        frame(SSPCU_OP_RDSR, 64'h0, 24);
        check(u_sspcu_host.rx[15:0], 16'h0303);
        wait_idle();
        frame(SSPCU_OP_NV_READ, {addr, 32'h0}, 48);
        check(u_sspcu_host.rx[7:0], 8'hFF);
        frame(SSPCU_OP_WEN, 64'h0, 8);
        frame(SSPCU_OP_VP_WRITE, {addr, pw[7:0], 24'h0}, 49);
        check(busy, 1'b0);
        frame(SSPCU_OP_VP_WRITE, {addr, pw[7:0], 24'h0}, 48);
        wait_idle();
        check({perr, wen}, 2'b00);
        @(posedge clk) prog_fault <= 1'b1;
        frame(SSPCU_OP_WEN, 64'h0, 8);
        frame(SSPCU_OP_VP_WRITE, {addr, pw[15:8], 24'h0}, 48);
        idle(PROG + 10);
        check({busy, perr}, 2'b11);
        @(posedge clk) prog_fault <= 1'b0;
        frame(SSPCU_OP_SCLR, 64'h0, 8);
        check({busy, perr}, 2'b00);
        frame(SSPCU_OP_WEN, 64'h0, 8);
        frame(SSPCU_OP_PW_PROG, wire_order(pw), 72);
        wait_idle();
        frame(SSPCU_OP_PW_READ, 64'h0, 136);
        check(u_sspcu_host.rx[127:64], wire_order(pw));
        check(u_sspcu_host.rx[63:0], wire_order(pw));
        frame(SSPCU_OP_WEN, 64'h0, 8);
        frame(SSPCU_OP_LOCK_CLR, 64'h0, 8);
        wait_idle();
        frame(SSPCU_OP_LOCK_READ, 64'h0, 24);
        check({lock, u_sspcu_host.rx[15:0]}, 17'h0_0000);
        frame(SSPCU_OP_PW_UNLOCK, ~wire_order(pw), 72);
        idle(PROG + 10);
        check({busy, perr}, 2'b11);
        frame(SSPCU_OP_LOCK_READ, 64'h0, 16);
        check(u_sspcu_host.oe_seen, 1'b0);
        frame(SSPCU_OP_SCLR, 64'h0, 8);
        check({busy, perr}, 2'b00);
        frame(SSPCU_OP_PW_UNLOCK, wire_order(pw), 72);
        wait_idle();
        check({lock, perr}, 2'b10);
        @(posedge clk) pwd_mode_bit <= 1'b0;
        frame(SSPCU_OP_PW_READ, 64'h0, 80);
        check(u_sspcu_host.oe_seen, 1'b0);
        frame(SSPCU_OP_WEN, 64'h0, 8);
        frame(SSPCU_OP_PW_PROG, ~wire_order(pw), 72);
        check(busy, 1'b0);
        frame(SSPCU_OP_RESET, 64'h0, 8);
        check({wen, lock}, 2'b01);
        summarize();
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule // sector_protection_command_unit_bench

`default_nettype wire

//--- verif/sspcu_asserts.sv
// Concurrent checks on the pins of the sector protection command unit.
// Assumes it is bound into sspcu_top with one clock and a synchronous reset.
`timescale 1ns/100ps
`default_nettype none

module sspcu_asserts
#(
    parameter int PROG_CYCLES  = 24,
    parameter int ERASE_CYCLES = 200
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic pwd_mode_bit,
    input wire logic prog_fault,
    input wire logic so,
    input wire logic so_oe,
    input wire logic op_in_progress_flag,
    input wire logic write_enable_latch,
    input wire logic program_error,
    input wire logic prot_lock_bit
);
    logic [15:0] busy_cnt_q;
    logic [15:0] busy_cnt_d;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Error hold is excluded: busy may then stand indefinitely
    always_comb busy_cnt_d = (op_in_progress_flag && !program_error) ? busy_cnt_q + 16'h0001
                                                                     : 16'h0000;
    always_ff @(posedge clk) busy_cnt_q <= sys_rst ? 16'h0000 : busy_cnt_d;

    // ****
    // Sequences and checks
    // ****
    sequence s_op_done;
        $fell(op_in_progress_flag) && !$past(program_error);
    endsequence
    sequence s_error_raised;
        $rose(program_error);
    endsequence

    chk_busy_after_frame: assert property ($rose(op_in_progress_flag) |-> cs_n && $past(cs_n))
        else $error("busy rose inside a frame");
    chk_wel_on_done: assert property (s_op_done |-> !write_enable_latch)
        else $error("write enable survived completion");
    chk_error_holds_busy: assert property (s_error_raised |-> op_in_progress_flag [*2])
        else $error("busy dropped with error raised");
    chk_error_sticky: assert property (program_error && !cs_n |=> program_error)
        else $error("error flag cleared inside a frame");
    chk_busy_bounded: assert property (busy_cnt_q <= ERASE_CYCLES + 1)
        else $error("busy lasted too long");
    chk_oe_idle: assert property (cs_n [*4] |-> !so_oe)
        else $error("output enabled outside a frame");
    chk_so_on_fall: assert property ($changed(so) && $past(so_oe) |-> !sck)
        else $error("serial out moved while clock high");
    chk_lock_source: assert property ($rose(prot_lock_bit) |->
                                      $past(op_in_progress_flag) || $past(sys_rst, 2))
        else $error("lock bit set without an operation");
    chk_wel_at_cs: assert property ($rose(write_enable_latch) |-> cs_n)
        else $error("write enable set inside a frame");
    chk_reset_quiet: assert property ($fell(sys_rst) |->
                                      !op_in_progress_flag && !program_error && !so_oe)
        else $error("flags not clear after reset");
endmodule // sspcu_asserts

bind sspcu_top sspcu_asserts #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES))
    u_sspcu_asserts (.clk(clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si),
                     .pwd_mode_bit(pwd_mode_bit), .prog_fault(prog_fault), .so(so),
                     .so_oe(so_oe), .op_in_progress_flag(op_in_progress_flag),
                     .write_enable_latch(write_enable_latch), .program_error(program_error),
                     .prot_lock_bit(prot_lock_bit));

`default_nettype wire

//--- verif/sspcu_host.sv
// SPI host model that frames commands for the sector protection unit.
// Assumes mode 0 and a clk far faster than the serial clock it makes.
`timescale 1ns/100ps
`default_nettype none

module sspcu_host
(
    input  wire logic clk,
    input  wire logic so,
    input  wire logic so_oe,
    output logic      sck,
    output logic      cs_n,
    output logic      si
);
    int           half = 3;
    logic [127:0] rx;
    logic         oe_seen;

    initial
    begin
        sck  = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end

    // Left aligned tx, msb first; clocks past bit 72 send zero
    task automatic xfer(input logic [71:0] tx, input int n);
        oe_seen = 1'b0;
        @(posedge clk);
        cs_n <= 1'b0;
        for (int i = 0; i < n; i++)
        begin
            si <= (i < 72) ? tx[71 - i] : 1'b0;
            repeat (half) @(posedge clk);
            sck <= 1'b1;
            repeat (half) @(posedge clk);
            rx      = {rx[126:0], so};
            oe_seen = oe_seen | so_oe;
            sck <= 1'b0;
        end
        repeat (half) @(posedge clk);
        cs_n <= 1'b1;
        // Released line must not keep its last value
        si   <= ~si;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask
endmodule // sspcu_host

`default_nettype wire

//--- verilog/sspcu_edge.sv
// Edge detector for the serial clock and chip select of the command unit.
// Assumes the pins are already synchronous to clk and the clock is far faster than sck.

`timescale 1ns/100ps
`default_nettype none

module sspcu_edge
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic sck,
    input  wire logic cs_n,
    output logic      sck_rise,
    output logic      sck_fall,
    output logic      cs_rise,
    output logic      cs_fall
);

    typedef struct packed
    {
        logic sck;
        logic cs_n;
    } sspcu_edge_type;

    sspcu_edge_type edge_q;
    sspcu_edge_type edge_d;

    always_comb
    begin
        edge_d      = edge_q;
        edge_d.sck  = sck;
        edge_d.cs_n = cs_n;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            edge_q.sck  <= 1'b0;
            edge_q.cs_n <= 1'b1;
        end
        else
        begin
            edge_q <= edge_d;
        end
    end

    // Serial clock edges only count inside a frame
    assign sck_rise = sck & ~edge_q.sck & ~cs_n;
    assign sck_fall = ~sck & edge_q.sck & ~cs_n;
    assign cs_rise  = cs_n & ~edge_q.cs_n;
    assign cs_fall  = ~cs_n & edge_q.cs_n;

endmodule // sspcu_edge

`default_nettype wire

//--- verilog/sspcu_pkg.sv
// Constants and types shared by the sector protection command unit.
// Assumes a 20 MHz system clock and an SPI host working in mode 0 or mode 3.

`default_nettype none

package sspcu_pkg;

    // ****************************************************************
    // Command opcodes
    // ****************************************************************
    localparam logic [7:0] SSPCU_OP_WEN       = 8'h06;
    localparam logic [7:0] SSPCU_OP_RDSR      = 8'h05;
    localparam logic [7:0] SSPCU_OP_SCLR      = 8'h30;
    localparam logic [7:0] SSPCU_OP_RESET     = 8'hF0;
    localparam logic [7:0] SSPCU_OP_SUSPEND   = 8'h75;
    localparam logic [7:0] SSPCU_OP_VP_WRITE  = 8'hE1;
    localparam logic [7:0] SSPCU_OP_NV_READ   = 8'hE2;
    localparam logic [7:0] SSPCU_OP_NV_PROG   = 8'hE3;
    localparam logic [7:0] SSPCU_OP_NV_ERASE  = 8'hE4;
    localparam logic [7:0] SSPCU_OP_LOCK_READ = 8'hA7;
    localparam logic [7:0] SSPCU_OP_LOCK_CLR  = 8'hA6;
    localparam logic [7:0] SSPCU_OP_PW_READ   = 8'hE7;
    localparam logic [7:0] SSPCU_OP_PW_PROG   = 8'hE8;
    localparam logic [7:0] SSPCU_OP_PW_UNLOCK = 8'hE9;

    // ****************************************************************
    // Frame lengths in rising clock edges
    // ****************************************************************
    localparam int         SSPCU_OPC_BITS  = 8;
    localparam int         SSPCU_ADDR_BITS = 32;
    localparam logic [6:0] SSPCU_CNT_OPC   = 7'd8;
    localparam logic [6:0] SSPCU_CNT_ADDR  = 7'd40;
    localparam logic [6:0] SSPCU_CNT_ADDRD = 7'd48;
    localparam logic [6:0] SSPCU_CNT_PW    = 7'd72;
    localparam logic [6:0] SSPCU_CNT_MAX   = 7'd127;
    localparam logic [5:0] SSPCU_IDX_BYTE  = 6'd7;
    localparam logic [5:0] SSPCU_IDX_PW    = 6'd63;

    // ****************************************************************
    // Layout and reset values
    // ****************************************************************
    localparam int          SSPCU_SECTOR_LSB = 18;
    localparam int          SSPCU_SR_BSY     = 0;
    localparam int          SSPCU_SR_WEN     = 1;
    localparam int          SSPCU_SR_PERR    = 6;
    localparam logic [7:0]  SSPCU_PROT_ON    = 8'h00;
    localparam logic [7:0]  SSPCU_PROT_OFF   = 8'hFF;
    localparam logic [7:0]  SSPCU_VPB_INIT   = 8'hFF;
    localparam logic [63:0] SSPCU_PW_INIT    = 64'hFFFF_FFFF_FFFF_FFFF;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int SSPCU_CLK_MHZ       = 20;
    localparam int SSPCU_PROG_TIME_US  = 100;
    localparam int SSPCU_ERASE_TIME_US = 1000;

    typedef enum logic [1:0]
    {
        SSPCU_IDLE = 2'b00,
        SSPCU_BUSY = 2'b01,
        SSPCU_HOLD = 2'b11
    } sspcu_st_type;

endpackage

`default_nettype wire

//--- verilog/sspcu_top.sv
// Sector protection command unit: decodes the protection commands of a serial flash.
// Assumes SPI pins synchronous to clk and an sck of at most a quarter of the clock rate.
//
// Behaviour
// - Volatile protection write is accepted only with the write-enable latch set.
// - Volatile write runs only if chip select rises right after data bit eight.
// - Program starts at chip select rise; busy flag high meanwhile; latch cleared at successful end.
// - Protection writes set error and busy flags like array programs.
// - Non-volatile read returns the sector byte, repeating every eight clocks.
// - Non-volatile program needs write enable and rise right after address.
// - Bulk erase needs write enable, rise after opcode; sets all bits to one.
// - Erase suspend is rejected during bulk erase; busy stays high until done.
// - Lock read repeats every eight clocks and works only when idle.
// - Lock clear needs write enable, rise after opcode; clears lock self-timed.
// - Password read: low byte first, msb first, repeating every 64 clocks.
// - Password read and program are ignored once password mode is chosen.
// - Password program needs write enable, 64 bits, exact rise; fault sets error.
// - Password unlock takes 64 bits and runs only on exact chip select rise.
// - Mismatch sets error and holds busy until status clear or reset.
// - Matching unlock password sets the lock bit.
// - Sample on rising serial clock edges, drive output on falling edges.
// - Software reset clears flags and volatile bits; keeps lock bit, password and non-volatile bits.

`timescale 1ns/100ps
`default_nettype none

module sspcu_top
    import sspcu_pkg::*;
#(
    parameter int NUM_SECTORS  = 256,
    parameter int PROG_CYCLES  = sspcu_pkg::SSPCU_PROG_TIME_US * sspcu_pkg::SSPCU_CLK_MHZ,
    parameter int ERASE_CYCLES = sspcu_pkg::SSPCU_ERASE_TIME_US * sspcu_pkg::SSPCU_CLK_MHZ
)
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic sck,
    input  wire logic cs_n,
    input  wire logic si,
    input  wire logic pwd_mode_bit,
    input  wire logic prog_fault,
    output logic      so,
    output logic      so_oe,
    output logic      op_in_progress_flag,
    output logic      write_enable_latch,
    output logic      program_error,
    output logic      prot_lock_bit
);

    import sspcu_pkg::*;

    localparam int SECT_W = (NUM_SECTORS > 1) ? $clog2(NUM_SECTORS) : 1;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed
    {
        sspcu_st_type st;
        logic         bsy;
        logic         wen;
        logic         perr;
        logic         lock;
        logic         lock_init;
        logic [7:0]   cmd;
        logic [6:0]   cnt;
        logic [63:0]  sr;
        logic [63:0]  tx;
        logic [5:0]   idx;
        logic [5:0]   idx_max;
        logic         rd;
        logic         so;
        logic         so_oe;
        logic [7:0]   op;
        logic [SECT_W-1:0] op_sect;
        logic [7:0]   op_data;
        logic [63:0]  op_pw;
        logic [63:0]  pw;
        logic [31:0]  timer;
    } sspcu_state_type;

    sspcu_state_type q;
    sspcu_state_type d;

    logic [7:0]        vp_mem [NUM_SECTORS];
    logic              nv_mem [NUM_SECTORS];
    logic              vp_we;
    logic              vp_rst_all;
    logic              nv_we;
    logic              nv_set_all;

    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;

    sspcu_edge u_edge
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .sck      (sck),
        .cs_n     (cs_n),
        .sck_rise (sck_rise),
        .sck_fall (sck_fall),
        .cs_rise  (cs_rise),
        .cs_fall  (cs_fall)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Low byte first on the wire, each byte msb first
    function automatic logic [63:0] byte_swap64(input logic [63:0] v);
        logic [63:0] r;
        r = '0;
        for (int i = 0; i < 8; i++)
        begin
            r[8*i +: 8] = v[8*(7-i) +: 8];
        end
        return r;
    endfunction

    function automatic logic [SECT_W-1:0] addr_to_sect(input logic [31:0] a);
        return a[SSPCU_SECTOR_LSB +: SECT_W];
    endfunction

    function automatic logic [31:0] op_cycles(input logic [7:0] op);
        return (op == SSPCU_OP_NV_ERASE) ? 32'(ERASE_CYCLES) : 32'(PROG_CYCLES);
    endfunction

    function automatic logic [63:0] status_word(input sspcu_state_type s);
        logic [7:0] b;
        b                = '0;
        b[SSPCU_SR_BSY]  = s.bsy;
        b[SSPCU_SR_WEN]  = s.wen;
        b[SSPCU_SR_PERR] = s.perr;
        return {b, 56'h0};
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        logic [63:0] rx;
        logic [7:0]  opc;
        logic        idle;
        logic        start;
        logic        fail;
        rx         = {q.sr[62:0], si};
        opc        = {q.cmd[6:0], si};
        idle       = (q.st == SSPCU_IDLE);
        start      = 1'b0;
        fail       = 1'b0;
        d          = q;
        vp_we      = 1'b0;
        vp_rst_all = 1'b0;
        nv_we      = 1'b0;
        nv_set_all = 1'b0;

        // Power-up lock follows the chosen protection mode, one cycle after reset
        if (!q.lock_init)
        begin
            d.lock_init = 1'b1;
            d.lock      = pwd_mode_bit;
        end

        if (cs_fall)
        begin
            d.cnt = '0;
            d.rd  = 1'b0;
        end

        // Serial input, rising edges only
        if (sck_rise)
        begin
            if (q.cnt < SSPCU_CNT_OPC)
            begin
                d.cmd = opc;
            end
            else
            begin
                d.sr = rx;
            end
            if (q.cnt != SSPCU_CNT_MAX)
            begin
                d.cnt = q.cnt + 7'd1;
            end
            if (q.cnt == SSPCU_CNT_OPC - 7'd1)
            begin
                d.idx = '0;
                unique case (opc)
                    SSPCU_OP_RDSR:
                    begin
                        d.rd      = 1'b1;
                        d.tx      = status_word(q);
                        d.idx_max = SSPCU_IDX_BYTE;
                    end
                    SSPCU_OP_LOCK_READ:
                    begin
                        d.rd      = idle;
                        d.tx      = {7'h00, q.lock, 56'h0};
                        d.idx_max = SSPCU_IDX_BYTE;
                    end
                    SSPCU_OP_PW_READ:
                    begin
                        d.rd      = idle & pwd_mode_bit;
                        d.tx      = byte_swap64(q.pw);
                        d.idx_max = SSPCU_IDX_PW;
                    end
                    default:
                    begin
                        d.rd = 1'b0;
                    end
                endcase
            end
            if ((q.cnt == SSPCU_CNT_ADDR - 7'd1) && (q.cmd == SSPCU_OP_NV_READ) && idle)
            begin
                d.rd      = 1'b1;
                d.idx     = '0;
                d.tx      = {nv_mem[addr_to_sect(rx[31:0])] ? SSPCU_PROT_OFF : SSPCU_PROT_ON,
                             56'h0};
                d.idx_max = SSPCU_IDX_BYTE;
            end
        end

        // Serial output, falling edges only; the address never advances
        if (sck_fall && q.rd)
        begin
            d.so    = q.tx[63 - q.idx];
            d.so_oe = 1'b1;
            if (q.idx == q.idx_max)
            begin
                d.idx = '0;
                if (q.cmd == SSPCU_OP_RDSR)
                begin
                    d.tx = status_word(q);
                end
            end
            else
            begin
                d.idx = q.idx + 6'd1;
            end
        end

        // Self-timed operation
        if (q.st == SSPCU_BUSY)
        begin
            d.timer = q.timer - 32'd1;
            if (q.timer <= 32'd1)
            begin
                // Lock clear leaves the non-volatile bits frozen
                fail = prog_fault | ((q.op == SSPCU_OP_NV_PROG || q.op == SSPCU_OP_NV_ERASE)
                       && !q.lock);
                if (q.op == SSPCU_OP_PW_UNLOCK)
                begin
                    if (q.op_pw == q.pw)
                    begin
                        d.lock = 1'b1;
                        d.st   = SSPCU_IDLE;
                        d.bsy  = 1'b0;
                    end
                    else
                    begin
                        d.perr = 1'b1;
                        d.st   = SSPCU_HOLD;
                    end
                end
                else if (fail)
                begin
                    // Error parks busy high, as an array program does
                    d.perr = 1'b1;
                    d.st   = SSPCU_HOLD;
                end
                else
                begin
                    d.st  = SSPCU_IDLE;
                    d.bsy = 1'b0;
                    d.wen = 1'b0;
                    unique case (q.op)
                        SSPCU_OP_VP_WRITE:  vp_we      = 1'b1;
                        SSPCU_OP_NV_PROG:   nv_we      = 1'b1;
                        SSPCU_OP_NV_ERASE:  nv_set_all = 1'b1;
                        SSPCU_OP_LOCK_CLR:  d.lock     = 1'b0;
                        SSPCU_OP_PW_PROG:   d.pw       = q.op_pw;
                        default:            d.pw       = q.pw;
                    endcase
                end
            end
        end

        // Frame end decides whether the command executes
        if (cs_rise)
        begin
            d.rd    = 1'b0;
            d.so_oe = 1'b0;
            unique case (q.cmd)
                SSPCU_OP_WEN:
                begin
                    if (idle && q.cnt == SSPCU_CNT_OPC)
                    begin
                        d.wen = 1'b1;
                    end
                end
                SSPCU_OP_SCLR:
                begin
                    if (q.cnt == SSPCU_CNT_OPC && q.st != SSPCU_BUSY)
                    begin
                        d.perr = 1'b0;
                        d.st   = SSPCU_IDLE;
                        d.bsy  = 1'b0;
                    end
                end
                SSPCU_OP_RESET:
                begin
                    if (q.cnt == SSPCU_CNT_OPC)
                    begin
                        d.perr     = 1'b0;
                        d.wen      = 1'b0;
                        d.bsy      = 1'b0;
                        d.st       = SSPCU_IDLE;
                        d.timer    = '0;
                        vp_rst_all = 1'b1;
                    end
                end
                SSPCU_OP_SUSPEND:
                begin
                    // No suspend here; busy keeps running to the end
                    d.st = q.st;
                end
                SSPCU_OP_VP_WRITE:  start = q.wen && q.cnt == SSPCU_CNT_ADDRD;
                SSPCU_OP_NV_PROG:   start = q.wen && q.cnt == SSPCU_CNT_ADDR;
                SSPCU_OP_NV_ERASE:  start = q.wen && q.cnt == SSPCU_CNT_OPC;
                SSPCU_OP_LOCK_CLR:  start = q.wen && q.cnt == SSPCU_CNT_OPC;
                SSPCU_OP_PW_PROG:
                begin
                    start = q.wen && pwd_mode_bit && q.cnt == SSPCU_CNT_PW;
                end
                SSPCU_OP_PW_UNLOCK: start = q.cnt == SSPCU_CNT_PW;
                default:            start = 1'b0;
            endcase
            // Guarded commands without the latch fall through here untouched
            if (start && idle)
            begin
                d.st      = SSPCU_BUSY;
                d.bsy     = 1'b1;
                d.op      = q.cmd;
                d.op_data = q.sr[7:0];
                d.op_sect = (q.cmd == SSPCU_OP_VP_WRITE) ? addr_to_sect(q.sr[39:8])
                                                         : addr_to_sect(q.sr[31:0]);
                d.op_pw   = byte_swap64(q.sr);
                d.timer   = op_cycles(q.cmd);
            end
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            q           <= '0;
            q.st        <= SSPCU_IDLE;
            q.pw        <= SSPCU_PW_INIT;
            q.idx_max   <= SSPCU_IDX_BYTE;
        end
        else
        begin
            q <= d;
        end
    end

    // Non-volatile bits are only set to one by a hardware reset or a bulk erase, never by a software reset
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < NUM_SECTORS; i++)
        begin
            if (sys_rst || vp_rst_all)
            begin
                vp_mem[i] <= SSPCU_VPB_INIT;
            end
            else if (vp_we && q.op_sect == SECT_W'(i))
            begin
                vp_mem[i] <= q.op_data;
            end
            if (sys_rst || nv_set_all)
            begin
                nv_mem[i] <= 1'b1;
            end
            else if (nv_we && q.op_sect == SECT_W'(i))
            begin
                nv_mem[i] <= 1'b0;
            end
        end
    end

    assign so                  = q.so;
    assign so_oe               = q.so_oe;
    assign op_in_progress_flag = q.bsy;
    assign write_enable_latch  = q.wen;
    assign program_error       = q.perr;
    assign prot_lock_bit       = q.lock;

endmodule // sspcu_top

`default_nettype wire
